// >>> count_pin_source.sv
// Far-side model of one external count pin
`timescale 1ns/1ps
module count_pin_source (
  // Clock
  input  wire logic clk_in,
  // Pin
  output logic      pin_out
);
  initial pin_out = 1'b1;

  // Falling edges, each level held for a whole number of clocks
  task automatic pulses(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      pin_out <= 1'b0;
      repeat (hold) @(posedge clk_in);
      pin_out <= 1'b1;
      repeat (hold - 1) @(posedge clk_in);
    end
  endtask
endmodule

// >>> dual_timer_counter.sv
// Two 8/16-bit timer/counters behind an AXI4-Lite register slave
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module dual_timer_counter #(
  parameter int NUM_TIMERS = 2
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // External pins
  input  wire logic        t0_count_pin_in,
  input  wire logic        t1_count_pin_in,
  input  wire logic        ext_irq0_pin_in,
  input  wire logic        ext_irq1_pin_in,
  // Interrupt vector acknowledge from the core
  input  wire logic        t0_vector_ack_in,
  input  wire logic        t1_vector_ack_in,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Status
  output logic             t0_overflow_flag_out,
  output logic             t1_overflow_flag_out,
  output logic             irq_out
);

  if (NUM_TIMERS != 2) begin : g_bad_count
    $error("dual_timer_counter serves exactly two timers");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] cnt_s1, cnt_s2, cnt_prev, irq_s1, irq_s2;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_s1   <= 2'h0;
      cnt_s2   <= 2'h0;
      cnt_prev <= 2'h0;
      irq_s1   <= 2'h0;
      irq_s2   <= 2'h0;
    end else begin
      cnt_s1   <= {t1_count_pin_in, t0_count_pin_in};
      cnt_s2   <= cnt_s1;
      cnt_prev <= cnt_s2;
      irq_s1   <= {ext_irq1_pin_in, ext_irq0_pin_in};
      irq_s2   <= irq_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic        aw_full, w_full, next_aw_full, next_w_full;
  logic [7:0]  aw_addr, next_aw_addr, w_data, next_w_data;
  logic        w_lane0, next_w_lane0;
  logic        next_awready, next_wready, next_bvalid, next_arready;
  logic        next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        do_write, wr_en, ar_take;
  logic [7:0]  rd_val;
  logic        rd_hit, wr_hit;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= timer_pkg::OFF_IRQ_MASK) && (a[1:0] == 2'b00);
  endfunction

  assign do_write = aw_full && w_full && !s_axi_bvalid_out;
  assign wr_hit   = mapped(aw_addr);
  assign wr_en    = do_write && wr_hit && w_lane0;
  assign ar_take  = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_hit   = mapped(s_axi_araddr_in);

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_w_full  = 1'b1;
      next_w_data  = s_axi_wdata_in[7:0];
      next_w_lane0 = s_axi_wstrb_in[0];
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
    end
    next_bvalid  = (s_axi_bvalid_out && !s_axi_bready_in) || do_write;
    next_bresp   = s_axi_bresp_out;
    if (do_write) begin
      next_bresp = wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end
    next_awready = !next_aw_full;
    next_wready  = !next_w_full;
    next_rvalid  = (s_axi_rvalid_out && !s_axi_rready_in) || ar_take;
    next_rdata   = s_axi_rdata_out;
    next_rresp   = s_axi_rresp_out;
    if (ar_take) begin
      next_rdata = {24'h00_0000, rd_hit ? rd_val : 8'h00};
      next_rresp = rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      aw_full           <= 1'b0;
      aw_addr           <= 8'h00;
      w_full            <= 1'b0;
      w_data            <= 8'h00;
      w_lane0           <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'h0;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= 2'h0;
    end else begin
      aw_full           <= next_aw_full;
      aw_addr           <= next_aw_addr;
      w_full            <= next_w_full;
      w_data            <= next_w_data;
      w_lane0           <= next_w_lane0;
      s_axi_awready_out <= next_awready;
      s_axi_wready_out  <= next_wready;
      s_axi_bvalid_out  <= next_bvalid;
      s_axi_bresp_out   <= next_bresp;
      s_axi_arready_out <= next_arready;
      s_axi_rvalid_out  <= next_rvalid;
      s_axi_rdata_out   <= next_rdata;
      s_axi_rresp_out   <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer cores

  logic [7:0] timer_control, timer_mode_reg, timer_control_b;
  logic [7:0] cnt_low [2];
  logic [7:0] cnt_high [2];
  logic [7:0] rld_low [2];
  logic [7:0] rld_high [2];
  logic [7:0] next_cnt_low [2];
  logic [7:0] next_cnt_high [2];
  logic       ovf [2];
  logic       pulse [2];
  logic [1:0] vec_ack;

  assign vec_ack = {t1_vector_ack_in, t0_vector_ack_in};

  for (genvar i = 0; i < 2; i++) begin : g_timer
    localparam logic [7:0] OFF_LOW  = (i == 0) ? timer_pkg::OFF_T0_LOW
                                               : timer_pkg::OFF_T1_LOW;
    localparam logic [7:0] OFF_HIGH = (i == 0) ? timer_pkg::OFF_T0_HIGH
                                               : timer_pkg::OFF_T1_HIGH;
    logic [3:0]          fld;
    timer_pkg::timer_mode_t mode;
    logic [2:0]          prescale_width;
    logic [7:0]          mask;
    logic                run, allow;

    assign fld  = timer_mode_reg[i*timer_pkg::MODE_STEP +: 4];
    assign mode = timer_pkg::timer_mode_t'(fld[1:0]);
    assign prescale_width = timer_control_b[i*timer_pkg::PRESCALE_STEP +: 3];
    assign mask = 8'hFF >> (3'd7 - prescale_width);
    assign run  = timer_control[timer_pkg::RUN_POS0 + i*timer_pkg::CTRL_STEP];
    assign allow = run && (!fld[timer_pkg::MODE_GATE] || irq_s2[i]);
    assign pulse[i] = allow && (fld[timer_pkg::MODE_CT]
                                ? (cnt_prev[i] && !cnt_s2[i]) : 1'b1);

    always_comb begin
      next_cnt_low[i]  = cnt_low[i];
      next_cnt_high[i] = cnt_high[i];
      ovf[i]           = 1'b0;
      if (pulse[i]) begin
        case (mode)
          timer_pkg::MODE_VAR: begin
            if ((cnt_low[i] & mask) == mask) begin
              next_cnt_low[i]  = cnt_low[i] & ~mask;
              next_cnt_high[i] = cnt_high[i] + 8'h01;
              ovf[i]           = (cnt_high[i] == 8'hFF);
            end else begin
              next_cnt_low[i] = cnt_low[i] + 8'h01;
            end
          end
          timer_pkg::MODE_AUTO16: begin
            if ({cnt_high[i], cnt_low[i]} == 16'hFFFF) begin
              next_cnt_high[i] = rld_high[i];
              next_cnt_low[i]  = rld_low[i];
              ovf[i]           = 1'b1;
            end else begin
              {next_cnt_high[i], next_cnt_low[i]} =
                {cnt_high[i], cnt_low[i]} + 16'h0001;
            end
          end
          timer_pkg::MODE_AUTO8: begin
            if (cnt_low[i] == 8'hFF) begin
              next_cnt_low[i] = cnt_high[i];
              ovf[i]          = 1'b1;
            end else begin
              next_cnt_low[i] = cnt_low[i] + 8'h01;
            end
          end
          default: begin
            next_cnt_low[i] = cnt_low[i];
          end
        endcase
      end
      if (wr_en && aw_addr == OFF_LOW) begin
        next_cnt_low[i] = w_data;
      end
      if (wr_en && aw_addr == OFF_HIGH) begin
        next_cnt_high[i] = w_data;
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
        cnt_low[i]  <= timer_pkg::COUNT_RST;
        cnt_high[i] <= timer_pkg::COUNT_RST;
      end else begin
        cnt_low[i]  <= next_cnt_low[i];
        cnt_high[i] <= next_cnt_high[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, reload and interrupt registers

  logic [7:0] next_ctrl, next_mode, next_ctrl_b;
  logic [7:0] next_rld_low [2];
  logic [7:0] next_rld_high [2];
  logic [1:0] irq_sts, irq_mask, next_sts, next_mask, ovf_vec;

  assign ovf_vec = {ovf[1], ovf[0]};

  always_comb begin
    next_ctrl   = timer_control;
    next_mode   = timer_mode_reg;
    next_ctrl_b = timer_control_b;
    next_rld_low[0]  = rld_low[0];
    next_rld_low[1]  = rld_low[1];
    next_rld_high[0] = rld_high[0];
    next_rld_high[1] = rld_high[1];
    next_sts    = irq_sts;
    next_mask   = irq_mask;
    if (wr_en) begin
      case (aw_addr)
        timer_pkg::OFF_CTRL:     next_ctrl = w_data;
        timer_pkg::OFF_MODE:     next_mode = w_data;
        timer_pkg::OFF_CTRL_B:   next_ctrl_b = w_data;
        timer_pkg::OFF_T0_RLOW:  next_rld_low[0] = w_data;
        timer_pkg::OFF_T1_RLOW:  next_rld_low[1] = w_data;
        timer_pkg::OFF_T0_RHIGH: next_rld_high[0] = w_data;
        timer_pkg::OFF_T1_RHIGH: next_rld_high[1] = w_data;
        timer_pkg::OFF_IRQ_STS:  next_sts = irq_sts & ~w_data[1:0];
        timer_pkg::OFF_IRQ_MASK: next_mask = w_data[1:0];
        default:                 next_mask = irq_mask;
      endcase
    end
    for (int k = 0; k < 2; k++) begin
      if (vec_ack[k]) begin
        next_ctrl[timer_pkg::FLAG_POS0 + k*timer_pkg::CTRL_STEP] = 1'b0;
      end
      if (ovf_vec[k]) begin
        next_ctrl[timer_pkg::FLAG_POS0 + k*timer_pkg::CTRL_STEP] = 1'b1;
        next_sts[k] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      timer_control   <= timer_pkg::CTRL_RST;
      timer_mode_reg  <= timer_pkg::MODE_RST;
      timer_control_b <= timer_pkg::CTRL_B_RST;
      rld_low[0]      <= timer_pkg::RELOAD_RST;
      rld_low[1]      <= timer_pkg::RELOAD_RST;
      rld_high[0]     <= timer_pkg::RELOAD_RST;
      rld_high[1]     <= timer_pkg::RELOAD_RST;
      irq_sts         <= 2'h0;
      irq_mask        <= 2'h0;
      irq_out         <= 1'b0;
      t0_overflow_flag_out <= 1'b0;
      t1_overflow_flag_out <= 1'b0;
    end else begin
      timer_control   <= next_ctrl;
      timer_mode_reg  <= next_mode;
      timer_control_b <= next_ctrl_b;
      rld_low[0]      <= next_rld_low[0];
      rld_low[1]      <= next_rld_low[1];
      rld_high[0]     <= next_rld_high[0];
      rld_high[1]     <= next_rld_high[1];
      irq_sts         <= next_sts;
      irq_mask        <= next_mask;
      irq_out         <= |(next_sts & next_mask);
      t0_overflow_flag_out <= next_ctrl[timer_pkg::FLAG_POS0];
      t1_overflow_flag_out <=
        next_ctrl[timer_pkg::FLAG_POS0 + timer_pkg::CTRL_STEP];
    end
  end

  always_comb begin
    case (s_axi_araddr_in)
      timer_pkg::OFF_CTRL:     rd_val = timer_control;
      timer_pkg::OFF_MODE:     rd_val = timer_mode_reg;
      timer_pkg::OFF_T0_LOW:   rd_val = cnt_low[0];
      timer_pkg::OFF_T1_LOW:   rd_val = cnt_low[1];
      timer_pkg::OFF_T0_HIGH:  rd_val = cnt_high[0];
      timer_pkg::OFF_T1_HIGH:  rd_val = cnt_high[1];
      timer_pkg::OFF_CTRL_B:   rd_val = timer_control_b;
      timer_pkg::OFF_T0_RLOW:  rd_val = rld_low[0];
      timer_pkg::OFF_T1_RLOW:  rd_val = rld_low[1];
      timer_pkg::OFF_T0_RHIGH: rd_val = rld_high[0];
      timer_pkg::OFF_T1_RHIGH: rd_val = rld_high[1];
      timer_pkg::OFF_IRQ_STS:  rd_val = {6'h00, irq_sts};
      timer_pkg::OFF_IRQ_MASK: rd_val = {6'h00, irq_mask};
      default:                 rd_val = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions on the timer cores and the interrupt output

  logic [15:0] t0_cnt;
  logic        t0_wr, t1_wr, ctl_wr;
  assign t0_cnt = {cnt_high[0], cnt_low[0]};
  assign t0_wr  = wr_en && (aw_addr == timer_pkg::OFF_T0_LOW
                            || aw_addr == timer_pkg::OFF_T0_HIGH);
  assign t1_wr  = wr_en && (aw_addr == timer_pkg::OFF_T1_LOW
                            || aw_addr == timer_pkg::OFF_T1_HIGH);
  assign ctl_wr = wr_en && aw_addr == timer_pkg::OFF_CTRL;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_wide_step;
    timer_mode_reg[1:0] == 2'b01 && !t0_wr && t0_cnt != 16'hFFFF;
  endsequence
  sequence s_wide_wrap;
    pulse[0] && timer_mode_reg[1:0] == 2'b01 && t0_cnt == 16'hFFFF && !t0_wr;
  endsequence

  property p_timer_tick;
    s_wide_step and (timer_mode_reg[3:2] == 2'b00 && timer_control[4])
      |=> t0_cnt == $past(t0_cnt) + 16'h0001;
  endproperty
  a_timer_tick: assert property (p_timer_tick) else $error("timer tick");
  property p_edge_count;
    s_wide_step and (timer_mode_reg[2] && timer_control[4]
      && (!timer_mode_reg[3] || irq_s2[0]) && cnt_prev[0] && !cnt_s2[0])
      |=> t0_cnt == $past(t0_cnt) + 16'h0001;
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("edge count");
  property p_no_edge;
    timer_mode_reg[2] && !(cnt_prev[0] && !cnt_s2[0]) && !t0_wr
      |=> $stable(t0_cnt);
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("count w/o edge");
  property p_gate;
    timer_mode_reg[3] && !irq_s2[0] && !t0_wr |=> $stable(t0_cnt);
  endproperty
  a_gate: assert property (p_gate) else $error("gate ignored");
  property p_run_keep;
    ctl_wr && !pulse[0] && !t0_wr |=> $stable(t0_cnt);
  endproperty
  a_run_keep: assert property (p_run_keep) else $error("run cleared");
  property p_wide_rld;
    s_wide_wrap |=> t0_cnt == {$past(rld_high[0]), $past(rld_low[0])}
      && timer_control[5] && t0_overflow_flag_out;
  endproperty
  a_wide_rld: assert property (p_wide_rld) else $error("wide reload");
  property p_byte_rld;
    pulse[1] && timer_mode_reg[5:4] == 2'b10 && cnt_low[1] == 8'hFF && !t1_wr
      |=> cnt_low[1] == $past(cnt_high[1]) && $stable(cnt_high[1])
      && timer_control[7];
  endproperty
  a_byte_rld: assert property (p_byte_rld) else $error("byte reload");
  property p_var_wrap;
    pulse[0] && timer_mode_reg[1:0] == 2'b00 && cnt_high[0] == 8'hFF
      && (cnt_low[0] & g_timer[0].mask) == g_timer[0].mask && !t0_wr
      |=> cnt_high[0] == 8'h00 && timer_control[5];
  endproperty
  a_var_wrap: assert property (p_var_wrap) else $error("var wrap");
  property p_ack;
    t0_vector_ack_in && !ovf[0] && !ctl_wr |=> !timer_control[5];
  endproperty
  a_ack: assert property (p_ack) else $error("ack clear");
  property p_irq;
    irq_out == |(irq_sts & irq_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level");

endmodule

// >>> dual_timer_counter_modes_bench.sv
// Self-checking bench for the dual timer/counter register block
`timescale 1ns/1ps
module dual_timer_counter_modes_bench;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        gate0   = 1'b0;
  logic        gate1   = 1'b0;
  logic        ack0    = 1'b0;
  logic        ack1    = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        pin0, pin1, awready, wready, bvalid, arready, rvalid;
  logic        flag0, flag1, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd_val;
  logic [7:0]  c1;
  int          n_fail  = 0;
  int          checks  = 0;
  int          cycles  = 0;

  always #5 clk = ~clk;

  count_pin_source src0 (.clk_in(clk), .pin_out(pin0));
  count_pin_source src1 (.clk_in(clk), .pin_out(pin1));

  dual_timer_counter uut (
    .ref_clk_in(clk), .sys_rst_in(rst),
    .t0_count_pin_in(pin0), .t1_count_pin_in(pin1),
    .ext_irq0_pin_in(gate0), .ext_irq1_pin_in(gate1),
    .t0_vector_ack_in(ack0), .t1_vector_ack_in(ack1),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready),
    .t0_overflow_flag_out(flag0), .t1_overflow_flag_out(flag1),
    .irq_out(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_val = rdata;
    resp   = rresp;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
    rd(a);
    chk(nm, {24'h00_0000, e}, rd_val);
    chk("rresp", 32'(timer_pkg::RESP_OKAY), 32'(resp));
  endtask

  task automatic wait_flag(input logic sel, input int lim);
    int k;
    k = 0;
    while (((sel ? flag1 : flag0) !== 1'b1) && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk_bit("overflow flag", 1'b1, sel ? flag1 : flag0);
  endtask

  task automatic run_gap(input int g);
    wr(timer_pkg::OFF_CTRL, 8'h10);
    repeat (g) @(posedge clk);
    wr(timer_pkg::OFF_CTRL, 8'h00);
    rd(timer_pkg::OFF_T0_LOW);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Reset values and an unmapped place
    rchk("control", timer_pkg::OFF_CTRL, 8'h00);
    rchk("mode", timer_pkg::OFF_MODE, 8'h00);
    rchk("control_b", timer_pkg::OFF_CTRL_B, 8'h44);
    rchk("t0 reload lo", timer_pkg::OFF_T0_RLOW, 8'h00);
    rchk("t0 reload hi", timer_pkg::OFF_T0_RHIGH, 8'h00);
    rchk("t1 reload lo", timer_pkg::OFF_T1_RLOW, 8'h00);
    rchk("t1 reload hi", timer_pkg::OFF_T1_RHIGH, 8'h00);
    rchk("irq status", timer_pkg::OFF_IRQ_STS, 8'h00);
    rd(8'h34);
    chk("bad rresp", 32'(timer_pkg::RESP_SLVERR), 32'(resp));
    chk("bad rdata", 32'h0000_0000, rd_val);
    wr(8'h34, 8'hFF);
    chk("bad bresp", 32'(timer_pkg::RESP_SLVERR), 32'(resp));
    // Timer rate and count kept across run
    wr(timer_pkg::OFF_MODE, 8'h01);
    run_gap(5);
    c1 = rd_val[7:0];
    chk_bit("counted", 1'b1, c1 != 8'h00);
    run_gap(5);
    chk("t0 low", 32'(c1) * 2, rd_val);
    run_gap(25);
    chk("t0 low", 32'(c1) * 3 + 20, rd_val);
    // Sixteen-bit reload, interrupt, flag clearing
    wr(timer_pkg::OFF_T0_RLOW, 8'h34);
    wr(timer_pkg::OFF_T0_RHIGH, 8'h12);
    wr(timer_pkg::OFF_T0_LOW, 8'hFE);
    wr(timer_pkg::OFF_T0_HIGH, 8'hFF);
    wr(timer_pkg::OFF_IRQ_MASK, 8'h01);
    wr(timer_pkg::OFF_CTRL, 8'h10);
    wait_flag(1'b0, 20);
    wr(timer_pkg::OFF_CTRL, 8'h20);
    chk_bit("irq", 1'b1, irq);
    rchk("t0 high", timer_pkg::OFF_T0_HIGH, 8'h12);
    rchk("irq status", timer_pkg::OFF_IRQ_STS, 8'h01);
    wr(timer_pkg::OFF_IRQ_MASK, 8'h00);
    chk_bit("irq masked", 1'b0, irq);
    wr(timer_pkg::OFF_IRQ_MASK, 8'h01);
    wr(timer_pkg::OFF_IRQ_STS, 8'h01);
    rchk("irq status", timer_pkg::OFF_IRQ_STS, 8'h00);
    chk_bit("irq", 1'b0, irq);
    @(posedge clk) ack0 <= 1'b1;
    @(posedge clk) ack0 <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit("t0 flag", 1'b0, flag0);
    wr(timer_pkg::OFF_CTRL, 8'h20);
    chk_bit("t0 flag", 1'b1, flag0);
    wr(timer_pkg::OFF_CTRL, 8'h00);
    chk_bit("t0 flag", 1'b0, flag0);
    // Eight-bit reload on timer 1
    wr(timer_pkg::OFF_MODE, 8'h20);
    wr(timer_pkg::OFF_T1_HIGH, 8'h80);
    wr(timer_pkg::OFF_T1_LOW, 8'hFD);
    wr(timer_pkg::OFF_CTRL, 8'h40);
    wait_flag(1'b1, 20);
    wr(timer_pkg::OFF_CTRL, 8'h00);
    rchk("t1 high", timer_pkg::OFF_T1_HIGH, 8'h80);
    rd(timer_pkg::OFF_T1_LOW);
    chk_bit("t1 low", 1'b1, rd_val[7:0] inside {[8'h80:8'h8F]});
    chk_bit("t0 flag", 1'b0, flag0);
    // Variable width mode, every prescaler width
    wr(timer_pkg::OFF_MODE, 8'h00);
    for (int n = 0; n < 8; n++) begin
      wr(timer_pkg::OFF_CTRL_B, {4'h4, 1'b0, 3'(n)});
      wr(timer_pkg::OFF_T0_HIGH, 8'hFF);
      wr(timer_pkg::OFF_T0_LOW, 8'hFE);
      wr(timer_pkg::OFF_CTRL, 8'h10);
      wait_flag(1'b0, 20);
      wr(timer_pkg::OFF_CTRL, 8'h20);
      if (n >= 4)
        rchk("t0 high", timer_pkg::OFF_T0_HIGH, 8'h00);
      if (n == 4) begin
        rd(timer_pkg::OFF_T0_LOW);
        chk("t0 low top", 32'h0000_0007, 32'(rd_val[7:5]));
      end
      wr(timer_pkg::OFF_CTRL, 8'h00);
    end
    // Counter function with gating per timer
    wr(timer_pkg::OFF_MODE, 8'hDD);
    wr(timer_pkg::OFF_T0_LOW, 8'h00);
    wr(timer_pkg::OFF_T0_HIGH, 8'h00);
    wr(timer_pkg::OFF_T1_LOW, 8'h00);
    wr(timer_pkg::OFF_T1_HIGH, 8'h00);
    gate0 <= 1'b1;
    wr(timer_pkg::OFF_CTRL, 8'h50);
    repeat (4) @(posedge clk);
    fork
      src0.pulses(3, 2);
      src1.pulses(3, 2);
    join
    repeat (6) @(posedge clk);
    rchk("t0 low", timer_pkg::OFF_T0_LOW, 8'h03);
    rchk("t1 low", timer_pkg::OFF_T1_LOW, 8'h00);
    gate0 <= 1'b0;
    gate1 <= 1'b1;
    repeat (4) @(posedge clk);
    fork
      src0.pulses(5, 1);
      src1.pulses(5, 1);
    join
    repeat (6) @(posedge clk);
    rchk("t0 low", timer_pkg::OFF_T0_LOW, 8'h03);
    rchk("t1 low", timer_pkg::OFF_T1_LOW, 8'h05);
    final_report;
  end
endmodule

// >>> timer_pkg.sv
// Constants for the dual timer/counter with AXI4-Lite registers
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_VAR    = 2'b00,
    MODE_AUTO16 = 2'b01,
    MODE_AUTO8  = 2'b10,
    MODE_SPLIT  = 2'b11
  } timer_mode_t;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_T0_LOW   = 8'h08;
  localparam logic [7:0] OFF_T1_LOW   = 8'h0C;
  localparam logic [7:0] OFF_T0_HIGH  = 8'h10;
  localparam logic [7:0] OFF_T1_HIGH  = 8'h14;
  localparam logic [7:0] OFF_CTRL_B   = 8'h18;
  localparam logic [7:0] OFF_T0_RLOW  = 8'h1C;
  localparam logic [7:0] OFF_T1_RLOW  = 8'h20;
  localparam logic [7:0] OFF_T0_RHIGH = 8'h24;
  localparam logic [7:0] OFF_T1_RHIGH = 8'h28;
  localparam logic [7:0] OFF_IRQ_STS  = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;

  // Field positions
  localparam int RUN_POS0  = 4;
  localparam int FLAG_POS0 = 5;
  localparam int CTRL_STEP = 2;
  localparam int MODE_STEP = 4;
  localparam int MODE_CT   = 2;
  localparam int MODE_GATE = 3;
  localparam int PRESCALE_STEP = 4;

  // Reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h44;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
